// [logic/result_cfg_pkg.sv]
// Constants, field layout and carrier types of the configuration bank
package result_cfg_pkg;

  // ---------------------------------------------------------------
  // Serial frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 25;  // Read flag, 8 address, 16 data
  localparam int HDR_BITS   = 9;   // Read flag and address
  localparam int DW         = 16;  // Register width
  localparam int RES_W      = 18;  // Conversion result width

  // ---------------------------------------------------------------
  // Bank selection
  // ---------------------------------------------------------------
  localparam logic [7:0] BANK_SEL_OFF   = 8'h03;
  localparam logic [7:0] BANK_SEL_RST   = 8'h02;
  localparam logic [7:0] BANK_ONE_CODE  = 8'h02;

  // ---------------------------------------------------------------
  // Data-control register
  // ---------------------------------------------------------------
  localparam logic [7:0]  DATA_CTRL_OFF = 8'h0D;
  localparam logic [15:0] DATA_CTRL_RST = 16'h2002;
  localparam int          FORMAT_BIT    = 13;
  localparam int          BLOCK_AVG_BIT = 6;
  localparam int          MOVING_AVG_BIT = 0;

  // ---------------------------------------------------------------
  // Bank 1 map: offsets and reset values, addressed by index
  // ---------------------------------------------------------------
  localparam int NREG = 20;
  localparam logic [7:0] REG_OFF [NREG] = '{
    8'h0D, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B,
    8'h1C, 8'h37, 8'h3C, 8'h92, 8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5};
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h2002, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [4:0] DATA_CTRL_IDX = 5'h00;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic twos_comp;
    logic block_avg;
    logic moving_avg;
  } coding_cfg_t;

  typedef struct packed {
    logic             valid;
    logic [RES_W-1:0] data;
  } result_t;

endpackage : result_cfg_pkg

// [logic/result_cfg_bank.sv]
// Configuration bank 1 with serial access and result coding path
`timescale 1ns/1ps
`default_nettype none

module result_cfg_bank (
  // Clock, reset, enable
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Configuration serial port pins
  input  wire logic cfg_sclk,
  input  wire logic cfg_cs_n,
  input  wire logic cfg_sdi,
  output logic      cfg_sdo,
  // Raw conversion results, straight binary
  input  wire result_cfg_pkg::result_t raw_in,
  // Coded results
  output result_cfg_pkg::result_t      res_out,
  // Current coding settings
  output result_cfg_pkg::coding_cfg_t  coding_out
);

  localparam int RW = result_cfg_pkg::RES_W;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic       sclk_prev_r;

  // Two flops on each pin
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r     <= 3'h2;  // Idle pins: clock low, deselected
      sync2_r     <= 3'h2;
      sclk_prev_r <= 1'b0;
    end else if (ce) begin
      sync1_r     <= {cfg_sclk, cfg_cs_n, cfg_sdi};
      sync2_r     <= sync1_r;
      sclk_prev_r <= sync2_r[2];
    end
  end

  logic sclk_s, cs_n_s, sdi_s, sclk_rise, sclk_fall;
  assign sclk_s    = sync2_r[2];
  assign cs_n_s    = sync2_r[1];
  assign sdi_s     = sync2_r[0];
  assign sclk_rise = sclk_s & ~sclk_prev_r;
  assign sclk_fall = ~sclk_s & sclk_prev_r;

  // ---------------------------------------------------------------
  // Serial frame capture
  // ---------------------------------------------------------------
  logic [result_cfg_pkg::FRAME_BITS-1:0] shift_r;
  logic [4:0]                            bit_cnt_r;
  logic [15:0]                           sdo_shift_r;
  logic [15:0]                           rd_data;
  logic                                  hdr_done;
  logic                                  frame_done;

  localparam logic [4:0] HDR_LAST   = 5'(result_cfg_pkg::HDR_BITS - 1);
  localparam logic [4:0] FRAME_LAST = 5'(result_cfg_pkg::FRAME_BITS - 1);

  assign hdr_done   = sclk_rise && !cs_n_s && bit_cnt_r == HDR_LAST;
  assign frame_done = sclk_rise && !cs_n_s && bit_cnt_r == FRAME_LAST;

  // Shift in on rising edges, count bits within a frame
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_r   <= '0;
      bit_cnt_r <= 5'h00;
    end else if (ce) begin
      if (cs_n_s) begin
        bit_cnt_r <= 5'h00;
      end else if (sclk_rise) begin
        shift_r   <= {shift_r[23:0], sdi_s};
        bit_cnt_r <= (bit_cnt_r == FRAME_LAST) ? 5'h00 : bit_cnt_r + 5'h01;
      end
    end
  end

  // Read data loads after the address, shifts out on falling edges
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo_shift_r <= 16'h0000;
      cfg_sdo     <= 1'b0;
    end else if (ce) begin
      if (hdr_done) begin
        sdo_shift_r <= rd_data;
      end else if (sclk_fall && !cs_n_s && bit_cnt_r > HDR_LAST) begin
        cfg_sdo     <= sdo_shift_r[15];
        sdo_shift_r <= {sdo_shift_r[14:0], 1'b0};
      end
    end
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0]  bank_sel_r;
  logic [15:0] regs_r [result_cfg_pkg::NREG];
  logic [7:0]  rd_addr, wr_addr;
  logic [15:0] wr_data;
  logic        wr_en;

  assign rd_addr = {shift_r[6:0], sdi_s};
  assign wr_addr = shift_r[22:15];
  assign wr_data = {shift_r[14:0], sdi_s};
  assign wr_en   = frame_done && !shift_r[23];

  // Bank select sits at a fixed offset reachable from every bank
  always_ff @(posedge clk) begin
    if (rst) begin
      bank_sel_r <= result_cfg_pkg::BANK_SEL_RST;
    end else if (ce && wr_en && wr_addr == result_cfg_pkg::BANK_SEL_OFF) begin
      bank_sel_r <= wr_data[7:0];
    end
  end

  logic bank_one;
  assign bank_one = bank_sel_r == result_cfg_pkg::BANK_ONE_CODE;

  // One storage word per mapped offset
  genvar gi;
  generate
    for (gi = 0; gi < result_cfg_pkg::NREG; gi++) begin : g_reg
      always_ff @(posedge clk) begin
        if (rst) begin
          regs_r[gi] <= result_cfg_pkg::REG_RST[gi];
        end else if (ce && wr_en && bank_one &&
                     wr_addr == result_cfg_pkg::REG_OFF[gi]) begin
          regs_r[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // Read mux, unmapped offsets read as zero
  always_comb begin
    rd_data = 16'h0000;
    if (rd_addr == result_cfg_pkg::BANK_SEL_OFF) begin
      rd_data = {8'h00, bank_sel_r};
    end else if (bank_one) begin
      for (int i = 0; i < result_cfg_pkg::NREG; i++) begin
        if (rd_addr == result_cfg_pkg::REG_OFF[i]) begin
          rd_data = regs_r[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Result coding path
  // ---------------------------------------------------------------
  logic [15:0]                 ctrl;
  result_cfg_pkg::coding_cfg_t live_cfg;
  result_cfg_pkg::coding_cfg_t snap_cfg;
  assign ctrl                = regs_r[result_cfg_pkg::DATA_CTRL_IDX];
  assign live_cfg.twos_comp  = ctrl[result_cfg_pkg::FORMAT_BIT];
  assign live_cfg.block_avg  = ctrl[result_cfg_pkg::BLOCK_AVG_BIT];
  assign live_cfg.moving_avg = ctrl[result_cfg_pkg::MOVING_AVG_BIT];

  // Settings follow the data-control register live, with no per-result sampling
  assign snap_cfg = live_cfg;

  logic          pair_half_r;
  logic [RW-1:0] pair_first_r;
  logic [RW-1:0] prev_r;
  logic [RW:0]   pair_sum, mov_sum;
  logic [RW-1:0] stage_v, mov_v, coded_v;
  logic          stage_ok;

  assign pair_sum = {1'b0, pair_first_r} + {1'b0, raw_in.data};
  assign stage_v  = snap_cfg.block_avg ? pair_sum[RW:1] : raw_in.data;
  assign stage_ok = raw_in.valid && (!snap_cfg.block_avg || pair_half_r);
  assign mov_sum  = {1'b0, prev_r} + {1'b0, stage_v};
  assign mov_v    = snap_cfg.moving_avg ? mov_sum[RW:1] : stage_v;
  // Straight binary to two's complement flips the top bit
  assign coded_v  = {mov_v[RW-1] ^ snap_cfg.twos_comp, mov_v[RW-2:0]};

  // Pair tracking for block averaging
  always_ff @(posedge clk) begin
    if (rst) begin
      pair_half_r  <= 1'b0;
      pair_first_r <= '0;
    end else if (ce && raw_in.valid) begin
      pair_half_r  <= snap_cfg.block_avg ? ~pair_half_r : 1'b0;
      pair_first_r <= raw_in.data;
    end
  end

  // Moving-average history and registered output
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_r     <= '0;
      res_out    <= '0;
      coding_out <= '0;
    end else if (ce) begin
      coding_out    <= live_cfg;
      res_out.valid <= stage_ok;
      if (stage_ok) begin
        prev_r       <= stage_v;
        res_out.data <= coded_v;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_ctrl_reset_val: assert property (@(posedge clk)
    rst |=> regs_r[0] == result_cfg_pkg::DATA_CTRL_RST)
    else $error("data control reset value wrong");

  chk_twos_code_msb: assert property (@(posedge clk) disable iff (rst)
    ce && raw_in.valid && !live_cfg.block_avg && !live_cfg.moving_avg
    |=> res_out.valid &&
        res_out.data[RW-1] == ($past(raw_in.data[RW-1]) ^
                               $past(live_cfg.twos_comp)))
    else $error("result coding does not follow format bit");

  sequence s_first_of_pair;
    ce && raw_in.valid && live_cfg.block_avg && !pair_half_r;
  endsequence

  chk_block_avg_gap: assert property (@(posedge clk) disable iff (rst)
    s_first_of_pair |=> !res_out.valid)
    else $error("first sample of a pair was delivered");

  chk_moving_avg_val: assert property (@(posedge clk) disable iff (rst)
    ce && stage_ok && live_cfg.moving_avg
    |=> res_out.data[RW-2:0] == $past(mov_sum[RW-1:1]))
    else $error("moving average value wrong");

  chk_result_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !stage_ok |=> $stable(res_out.data))
    else $error("result changed without a new sample");

  chk_bank_gate: assert property (@(posedge clk) disable iff (rst)
    ce && wr_en && !bank_one |=> $stable(regs_r[0]))
    else $error("bank 1 written while not selected");

endmodule : result_cfg_bank

`default_nettype wire

// [sim/cfg_host_model.sv]
// Host model driving the configuration serial port
`timescale 1ns/1ps
`default_nettype none

module cfg_host_model (
  // Clock
  input  wire logic clk,
  // Serial port pins
  output logic      sclk,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // Idle pins: clock parked low, port deselected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // One 25-bit frame, MSB first; data bits gathered before each rise
  task automatic frame(input logic rd, input logic [7:0] addr,
                       input logic [15:0] wd, output logic [15:0] rdat);
    logic [24:0] word;
    word = {rd, addr, wd};
    rdat = '0;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (int i = 24; i >= 0; i--) begin
      sdi = word[i];
      repeat (5) @(posedge clk);
      if (i < 16) rdat = {rdat[14:0], sdo};
      #1 sclk = 1'b1;
      repeat (5) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (8) @(posedge clk);
    #1 cs_n = 1'b1;
    sdi = ~sdi;  // Released line shows no stale bit
  endtask : frame
endmodule : cfg_host_model

`default_nettype wire

// [sim/result_cfg_bank_test.sv]
// Self-checking bench for the result configuration bank
`timescale 1ns/1ps
`default_nettype none

module result_cfg_bank_test;
  logic                        clk;
  logic                        rst;
  logic                        ce;
  logic                        sclk;
  logic                        cs_n;
  logic                        sdi;
  logic                        sdo;
  result_cfg_pkg::result_t     raw_in;
  result_cfg_pkg::result_t     res_out;
  result_cfg_pkg::coding_cfg_t coding_out;
  logic [17:0]                 got;
  int                          fails = 0;
  int                          checks = 0;
  int                          cycles = 0;

  result_cfg_bank u_dut (.clk(clk), .rst(rst), .ce(ce), .cfg_sclk(sclk),
    .cfg_cs_n(cs_n), .cfg_sdi(sdi), .cfg_sdo(sdo), .raw_in(raw_in),
    .res_out(res_out), .coding_out(coding_out));
  cfg_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo));

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Watchdog against a hung run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] unused;
    u_host.frame(1'b0, a, d, unused);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    u_host.frame(1'b1, a, 16'h0000, v);
    check({16'h0000, v}, {16'h0000, exp});
  endtask : rd

  // One-cycle result pulse
  task automatic push(input logic [17:0] d);
    @(posedge clk);
    #1 raw_in = {1'b1, d};
    @(posedge clk);
    #1 raw_in.valid = 1'b0;
  endtask : push

  // Bounded wait for a coded result
  task automatic pull(output logic [17:0] d);
    int n;
    n = 0;
    while (res_out.valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    check({31'h0, res_out.valid}, 32'h1);
    d = res_out.data;
  endtask : pull

  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    raw_in = '0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1 check({29'h0, coding_out}, 32'h4);
    rd(8'h0D, 16'h2002);
    push(18'h00005);
    pull(got);
    check({14'h0, got}, {14'h0, 18'h20005});
    wr(8'h0D, 16'h0002);
    rd(8'h0D, 16'h0002);
    check({29'h0, coding_out}, 32'h0);
    push(18'h20005);
    pull(got);
    check({14'h0, got}, {14'h0, 18'h20005});
    wr(8'h0D, 16'h0042);
    check({29'h0, coding_out}, 32'h2);
    check({14'h0, res_out.data}, {14'h0, 18'h20005});
    push(18'h00100);
    push(18'h00203);
    pull(got);
    check({14'h0, got}, {14'h0, 18'h00181});
    wr(8'h0D, 16'h0003);
    check({29'h0, coding_out}, 32'h1);
    push(18'h00010);
    pull(got);
    check({14'h0, got}, {14'h0, 18'h000C8});
    // Frozen enable ignores a result and keeps the history
    @(posedge clk);
    #1 ce = 1'b0;
    raw_in = {1'b1, 18'h3FFFF};
    @(posedge clk);
    #1 raw_in.valid = 1'b0;
    ce = 1'b1;
    check({31'h0, res_out.valid}, 32'h0);
    push(18'h00031);
    pull(got);
    check({14'h0, got}, {14'h0, 18'h00020});
    wr(8'h03, 16'h0000);
    wr(8'h0D, 16'h2002);
    rd(8'h0D, 16'h0000);
    wr(8'h03, 16'h0002);
    rd(8'h0D, 16'h0003);
    rd(8'h10, 16'h0000);
    // Second reset in mid-run restores the default coding
    @(posedge clk);
    #1 rst = 1'b1;
    @(posedge clk);
    #1 rst = 1'b0;
    rd(8'h0D, 16'h2002);
    check({29'h0, coding_out}, 32'h4);
    tally_and_finish();
  end
endmodule : result_cfg_bank_test

`default_nettype wire
